// ### design/rxcp_port_select.sv
/*
  Receiver control-port selection: serial/parallel pin sharing, slot
  power-down, FM converter strobe/clock sequencing.
  Assumes pins are synchronous to i_clk; a floating pad is flagged on
  i_pad_float and then reads low.
*/
`timescale 1ns/1ps
`default_nettype none
module rxcp_port_select #(
  parameter int unsigned WORD_W = rxcp_pkg::WORD_W_DEF
) (
  input wire logic i_clk,                        // System clock, 50 MHz
  input wire logic i_reset_n,                    // Sync reset, active low
  input wire logic [rxcp_pkg::PAD_N-1:0] i_pad_float, // Pad has no driver
  input wire logic i_serial_port_select,         // Serial/parallel select
  input wire logic i_idle_or_latch_pin,          // Idle or latch strobe
  input wire logic i_fm_select_or_sdata_pin,     // FM select or data in
  output logic o_fm_select_or_sdata_pin,         // Data out
  output logic o_fm_select_or_sdata_oe_n,        // Data drive, active low
  input wire logic i_sleep_or_sclk_pin,          // Sleep or serial clock
  input wire logic i_rx_slot_low,                // Slot mode, active low
  input wire logic i_fm_conv_strobe,             // FM converter strobe
  input wire logic i_fm_conv_clock,              // FM converter clock
  output logic o_serial_mode,                    // Serial mode active
  output logic o_idle_low_ctl,                   // Idle control, active low
  output logic o_fm_select_low_ctl,              // FM select, active low
  output logic o_sleep_low_ctl,                  // Sleep control, active low
  output logic [WORD_W-1:0] o_serial_word,       // Last latched word
  output logic o_serial_word_valid,              // Word latched pulse
  output logic o_core_run,                       // Non-slot functions run
  output logic o_osc_ref_run,                    // Osc, buffer, divider run
  output logic o_fm_conv_start,                  // Conversion start pulse
  output logic o_fm_conv_busy,                   // Conversion in progress
  output logic [3:0] o_fm_conv_step              // Converter clock step
);
  import rxcp_pkg::*;

  // ****************************************
  // Parameter check
  // ****************************************
  if (WORD_W < 2 || WORD_W > 32)
  begin : g_bad_width
    $error("WORD_W must be 2 to 32");
  end

  typedef struct packed {
    logic serial;
    logic idle;
    logic fmsel;
    logic sleep;
    logic stb_q;
    logic sclk_q;
    logic fstb_q;
    logic fclk_q;
    logic framing;
    logic [WORD_W-1:0] word;
    logic word_vld;
    logic sdo;
    logic sdo_oe_n;
    logic core_run;
    logic fm_start;
    logic fm_busy;
    logic [3:0] fm_step;
  } rxcp_st_t;

  rxcp_st_t st_reg;
  rxcp_st_t st_next;
  logic sel;
  logic latch;
  logic sdi;
  logic sclk;
  logic fstb;
  logic fclk;

  rxcp_ser_if #(.W(WORD_W)) ser ();

  // ****************************************
  // Pad values
  // ****************************************
  // Floating pads read low
  assign sel = i_serial_port_select & ~i_pad_float[PAD_SEL];
  assign latch = i_idle_or_latch_pin & ~i_pad_float[PAD_LATCH];
  assign sdi = i_fm_select_or_sdata_pin & ~i_pad_float[PAD_SDATA];
  assign sclk = i_sleep_or_sclk_pin & ~i_pad_float[PAD_SCLK];
  assign fstb = i_fm_conv_strobe & ~i_pad_float[PAD_FSTB];
  assign fclk = i_fm_conv_clock & ~i_pad_float[PAD_FCLK];

  // ****************************************
  // Serial shifter
  // ****************************************
  // Frame opens on latch rise, bits taken on clock rises
  assign ser.frame_start = sel & latch & ~st_reg.stb_q;
  assign ser.shift_en = sel & st_reg.framing & latch & sclk & ~st_reg.sclk_q;
  assign ser.bit_in = sdi;
  assign ser.load_word = st_reg.word;

  rxcp_shifter #(.W(WORD_W)) u_shifter (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .ser(ser)
  );

  // ****************************************
  // Next state
  // ****************************************
  // Mode selection, serial framing, FM sequencing
  always_comb
  begin
    st_next = st_reg;
    st_next.word_vld = 1'h0;
    st_next.fm_start = 1'h0;
    st_next.serial = sel;
    st_next.stb_q = latch;
    st_next.sclk_q = sclk;
    st_next.fstb_q = fstb;
    st_next.fclk_q = fclk;
    st_next.core_run = i_rx_slot_low;
    if (!sel)
    begin
      st_next.idle = latch;
      st_next.fmsel = sdi;
      st_next.sleep = sclk;
      st_next.framing = 1'h0;
      st_next.sdo_oe_n = 1'h1;
    end
    else
    begin
      if (ser.frame_start)
      begin
        st_next.framing = 1'h1;
      end
      else if (st_reg.framing && !latch)
      begin
        st_next.framing = 1'h0;
        st_next.word = ser.word;
        st_next.word_vld = 1'h1;
      end
      if (st_reg.framing && latch && !sclk && st_reg.sclk_q)
      begin
        st_next.sdo = ser.rd_bit;
        st_next.sdo_oe_n = ~ser.rd_mode;
      end
      if (!latch)
      begin
        st_next.sdo_oe_n = 1'h1;
      end
    end
    // Strobe restarts the converter, clock rises step it
    if (!i_rx_slot_low)
    begin
      st_next.fm_busy = 1'h0;
    end
    else if (fstb && !st_reg.fstb_q)
    begin
      st_next.fm_start = 1'h1;
      st_next.fm_busy = 1'h1;
      st_next.fm_step = 4'h0;
    end
    else if (st_reg.fm_busy && fclk && !st_reg.fclk_q)
    begin
      st_next.fm_step = st_reg.fm_step + 4'h1;
      if (st_reg.fm_step == FM_LAST_STEP)
      begin
        st_next.fm_busy = 1'h0;
      end
    end
    if (!i_reset_n)
    begin
      st_next = '0;
      st_next.idle = CTL_RESET;
      st_next.fmsel = CTL_RESET;
      st_next.sleep = CTL_RESET;
      st_next.sdo_oe_n = OE_N_RESET;
    end
  end

  // State register
  always_ff @(posedge i_clk)
  begin
    st_reg <= st_next;
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign o_serial_mode = st_reg.serial;
  assign o_idle_low_ctl = st_reg.idle;
  assign o_fm_select_low_ctl = st_reg.fmsel;
  assign o_sleep_low_ctl = st_reg.sleep;
  assign o_serial_word = st_reg.word;
  assign o_serial_word_valid = st_reg.word_vld;
  assign o_fm_select_or_sdata_pin = st_reg.sdo;
  assign o_fm_select_or_sdata_oe_n = st_reg.sdo_oe_n;
  assign o_core_run = st_reg.core_run;
  assign o_osc_ref_run = 1'h1; // Never stopped, even in slot mode
  assign o_fm_conv_start = st_reg.fm_start;
  assign o_fm_conv_busy = st_reg.fm_busy;
  assign o_fm_conv_step = st_reg.fm_step;

  // ****************************************
  // Assertions
  // ****************************************
  property p_mode_follow;
    @(posedge i_clk) disable iff (!i_reset_n)
    (sel ##1 sel) |-> o_serial_mode ##1 $stable(o_idle_low_ctl);
  endproperty
  a_mode_follow: assert property (p_mode_follow) else $error("serial mode wrong");

  property p_idle_par;
    @(posedge i_clk) disable iff (!i_reset_n)
    !sel |=> o_idle_low_ctl == $past(latch);
  endproperty
  a_idle_par: assert property (p_idle_par) else $error("idle not followed");

  property p_oe_serial;
    @(posedge i_clk) disable iff (!i_reset_n)
    !o_fm_select_or_sdata_oe_n |-> o_serial_mode && $past(sel);
  endproperty
  a_oe_serial: assert property (p_oe_serial) else $error("data driven outside serial");

  property p_sel_float;
    @(posedge i_clk) disable iff (!i_reset_n)
    i_pad_float[PAD_SEL] |=> !o_serial_mode;
  endproperty
  a_sel_float: assert property (p_sel_float) else $error("floating select not low");

  property p_latch_float;
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_pad_float[PAD_LATCH] && !sel) |=> !o_idle_low_ctl;
  endproperty
  a_latch_float: assert property (p_latch_float) else $error("floating idle not low");

  property p_slot_stop;
    @(posedge i_clk) disable iff (!i_reset_n)
    !i_rx_slot_low |=> !o_core_run && !o_fm_conv_busy && o_osc_ref_run;
  endproperty
  a_slot_stop: assert property (p_slot_stop) else $error("slot mode not stopping");

  property p_fm_start;
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_rx_slot_low && fstb && !st_reg.fstb_q) |=>
      o_fm_conv_start && o_fm_conv_busy && o_fm_conv_step == 4'h0;
  endproperty
  a_fm_start: assert property (p_fm_start) else $error("strobe missed");

  property p_sleep_serial;
    @(posedge i_clk) disable iff (!i_reset_n)
    (sel && st_reg.serial) |=> $stable(o_sleep_low_ctl);
  endproperty
  a_sleep_serial: assert property (p_sleep_serial) else $error("sleep moved in serial");

  property p_word_latch;
    @(posedge i_clk) disable iff (!i_reset_n)
    (sel && st_reg.framing && !latch && !ser.frame_start) |=>
      o_serial_word_valid ##1 !o_serial_word_valid;
  endproperty
  a_word_latch: assert property (p_word_latch) else $error("word not latched");

  c_frame: cover property (@(posedge i_clk) disable iff (!i_reset_n) o_serial_word_valid);
  c_fm_done: cover property (@(posedge i_clk) disable iff (!i_reset_n) $fell(o_fm_conv_busy));
  c_readback: cover property (@(posedge i_clk) disable iff (!i_reset_n)
    !o_fm_select_or_sdata_oe_n);
endmodule // rxcp_port_select
`default_nettype wire

// ### design/rxcp_pkg.sv
/*
  Constants shared by the receiver control-port selection logic.
  Assumes a single 50 MHz system clock and pads that pull open inputs low.
*/
package rxcp_pkg;
  // ****************************************
  // Clock and modem timing
  // ****************************************
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned FM_STROBE_HZ = 40_000;
  localparam int unsigned FM_CLOCK_HZ = 360_000;
  // FM converter clock edges per strobe period
  localparam int unsigned FM_STEPS = FM_CLOCK_HZ / FM_STROBE_HZ;
  localparam logic [3:0] FM_LAST_STEP = 4'(FM_STEPS - 1);

  // ****************************************
  // Serial word and pad indices
  // ****************************************
  localparam int unsigned WORD_W_DEF = 16;
  localparam int unsigned PAD_SEL = 0;
  localparam int unsigned PAD_LATCH = 1;
  localparam int unsigned PAD_SDATA = 2;
  localparam int unsigned PAD_SCLK = 3;
  localparam int unsigned PAD_FSTB = 4;
  localparam int unsigned PAD_FCLK = 5;
  localparam int unsigned PAD_N = 6;

  // ****************************************
  // Values after reset
  // ****************************************
  localparam logic CTL_RESET = 1'h1;
  localparam logic OE_N_RESET = 1'h1;
endpackage

// ### design/rxcp_ser_if.sv
/*
  Carrier between the port selector and its serial shifter.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface rxcp_ser_if #(parameter int unsigned W = 16);
  logic frame_start;
  logic shift_en;
  logic bit_in;
  logic [W-1:0] load_word;
  logic [W-1:0] word;
  logic rd_bit;
  logic rd_mode;
  modport core (output frame_start, shift_en, bit_in, load_word,
                input word, rd_bit, rd_mode);
  modport shifter (input frame_start, shift_en, bit_in, load_word,
                   output word, rd_bit, rd_mode);
endinterface
`default_nettype wire

// ### design/rxcp_shifter.sv
/*
  Serial shifter: collects data bits, keeps the read flag and
  presents read-back bits MSB first.
  Assumes the selector only pulses shift_en inside a frame.
*/
`timescale 1ns/1ps
`default_nettype none
module rxcp_shifter #(
  parameter int unsigned W = 16
) (
  input wire logic i_clk,        // System clock
  input wire logic i_reset_n,    // Sync reset, active low
  rxcp_ser_if.shifter ser        // Link to the selector
);
  import rxcp_pkg::*;

  typedef struct packed {
    logic [W-1:0] shift;
    logic [W-1:0] rd_buf;
    logic first;
    logic rd_mode;
  } rxcp_sh_t;

  rxcp_sh_t sh_reg;
  rxcp_sh_t sh_next;

  // ****************************************
  // Next state
  // ****************************************
  // First bit of a frame picks read mode
  always_comb
  begin
    sh_next = sh_reg;
    if (!i_reset_n)
    begin
      sh_next = '0;
    end
    else if (ser.frame_start)
    begin
      sh_next.first = 1'h1;
      sh_next.rd_mode = 1'h0;
      sh_next.rd_buf = ser.load_word;
    end
    else if (ser.shift_en)
    begin
      sh_next.shift = {sh_reg.shift[W-2:0], ser.bit_in};
      sh_next.first = 1'h0;
      if (sh_reg.first)
      begin
        sh_next.rd_mode = ser.bit_in;
      end
      else if (sh_reg.rd_mode)
      begin
        sh_next.rd_buf = {sh_reg.rd_buf[W-2:0], 1'h0};
      end
    end
  end

  // State register
  always_ff @(posedge i_clk)
  begin
    sh_reg <= sh_next;
  end

  // Outputs to the selector
  assign ser.word = sh_reg.shift;
  assign ser.rd_bit = sh_reg.rd_buf[W-1];
  assign ser.rd_mode = sh_reg.rd_mode;
endmodule // rxcp_shifter
`default_nettype wire

// ### sim/rxcp_modem.sv
/*
  Behavioural modem model driving the shared control pins and FM timing.
  Assumes the bench resolves the data wire and calls tasks at falling edges.
*/
`timescale 1ns/1ps
`default_nettype none
module rxcp_modem (
  input wire logic i_clk,   // System clock
  input wire logic i_sdata, // Resolved data wire
  output logic o_sel,       // Serial/parallel select
  output logic o_latch,     // Idle or latch strobe
  output logic o_sdata,     // Data value driven
  output logic o_sdata_en,  // Modem drives data wire
  output logic o_sclk,      // Serial clock in frames, low between them; sleep level in parallel use
  output logic o_fstb,      // FM converter strobe
  output logic o_fclk       // FM converter clock
);
  // Offset controls are filtered analog levels, not modelled
  initial
  begin
    {o_sel, o_latch, o_sdata, o_sdata_en, o_sclk, o_fstb, o_fclk} = 7'h00;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge i_clk);
  endtask

  // Parallel levels; data is driven while in parallel use
  task automatic set_pins(input logic s, input logic a, input logic b, input logic c);
    o_sel = s;
    o_latch = a;
    o_sdata = b;
    o_sdata_en = 1'b1;
    o_sclk = c;
  endtask

  // Frame: latch rise, bits MSB first on clock rises, latch fall
  task automatic frame(input logic [16:0] bits, input int n, input bit rd, input int cut,
                       output logic [15:0] got);
    got = 16'h0000;
    o_latch = 1'b1;
    tick(2);
    for (int k = n - 1; k >= 0; k--)
    begin
      if (n - 1 - k == cut)
      begin
        o_sel = 1'b0;
        break;
      end
      // Read-back: device owns the wire after the first bit
      if (rd && k != n - 1)
        got = {got[14:0], i_sdata};
      else
      begin
        o_sdata_en = 1'b1;
        o_sdata = bits[k];
      end
      tick(2);
      o_sclk = 1'b1;
      tick(2);
      o_sclk = 1'b0;
      if (rd)
        o_sdata_en = 1'b0;
      tick(2);
    end
    o_latch = 1'b0;
    o_sdata_en = 1'b0;
    tick(2);
  endtask

  // Strobe every 1250 cycles (40 kHz), nine clock rises of 138 cycles
  task automatic fm_burst(input int n);
    repeat (n)
    begin
      o_fstb = 1'b1;
      tick(4);
      o_fstb = 1'b0;
      tick(4);
      repeat (9)
      begin
        o_fclk = 1'b1;
        tick(69);
        o_fclk = 1'b0;
        tick(69);
      end
    end
  endtask
endmodule // rxcp_modem
`default_nettype wire

// ### sim/testbench.sv
/*
  Self-checking bench for the control-port selector with a modem model.
  Assumes the design package and the selector are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import rxcp_pkg::*;
  logic clk, rst_n, slot, sel, latch, sd_m, sd_en, sclk, fstb, fclk, sd_wire;
  logic sd_o, sd_oe_n, smode, idle_c, fms_c, slp_c, wvalid, core_run, osc_run, fstart, fbusy;
  logic [5:0] flt;
  logic [15:0] word, last_w, w, got;
  logic [3:0] fstep;
  logic [2:0] e3;
  logic [31:0] rng, r;
  logic [15:0] word_q[$];
  logic fm_q[$];
  int n_fail, checked;

  // Wire resolution: device, then modem, else pull-down reads low
  assign sd_wire = !sd_oe_n ? sd_o : (sd_en ? sd_m : 1'b0);

  rxcp_port_select u_rxcp_port_select (.i_clk(clk), .i_reset_n(rst_n),
    .i_pad_float({flt[5:3], flt[2] | (sd_oe_n & ~sd_en), flt[1:0]}),
    .i_serial_port_select(sel), .i_idle_or_latch_pin(latch),
    .i_fm_select_or_sdata_pin(sd_wire), .o_fm_select_or_sdata_pin(sd_o),
    .o_fm_select_or_sdata_oe_n(sd_oe_n), .i_sleep_or_sclk_pin(sclk),
    .i_rx_slot_low(slot), .i_fm_conv_strobe(fstb), .i_fm_conv_clock(fclk),
    .o_serial_mode(smode), .o_idle_low_ctl(idle_c), .o_fm_select_low_ctl(fms_c),
    .o_sleep_low_ctl(slp_c), .o_serial_word(word), .o_serial_word_valid(wvalid),
    .o_core_run(core_run), .o_osc_ref_run(osc_run), .o_fm_conv_start(fstart),
    .o_fm_conv_busy(fbusy), .o_fm_conv_step(fstep));
  rxcp_modem u_rxcp_modem (.i_clk(clk), .i_sdata(sd_wire), .o_sel(sel), .o_latch(latch),
    .o_sdata(sd_m), .o_sdata_en(sd_en), .o_sclk(sclk), .o_fstb(fstb), .o_fclk(fclk));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  task automatic cmpw(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cmp3(input string nm, input logic [2:0] e, input logic [2:0] g);
    cmpw(nm, {13'h0, e}, {13'h0, g});
  endtask

  task automatic conclude();
    $display("Counts: checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Monitor: each result pops the oldest note
  always @(posedge clk)
  begin
    #1;
    if (wvalid === 1'b1)
      cmpw("serial word", word_q.size() ? word_q.pop_front() : ~word, word);
    if (fstart === 1'b1)
      cmp3("start busy,step", fm_q.size() ? 3'h4 : 3'h0, {fbusy, fstep[1:0]});
    if (fstart === 1'b1 && fm_q.size())
      void'(fm_q.pop_front());
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    conclude();
  end

  initial
  begin
    {n_fail, checked, rst_n, flt} = '0;
    rng = 32'h16C0C069;
    slot = 1'b1;
    repeat (12) @(negedge clk);
    cmp3("reset ctls", 3'h7, {idle_c, fms_c, slp_c});
    cmp3("reset oe,osc,mode", 3'h6, {sd_oe_n, osc_run, smode});
    rst_n = 1'b1;
    // Parallel controls follow pins one cycle late; random open pads and slot input
    repeat (8)
    begin
      r = xs();
      flt = {r[8:4], r[3] | r[10]};
      slot = r[9];
      u_rxcp_modem.set_pins(r[10], r[0], r[1], r[2]);
      u_rxcp_modem.tick(2);
      e3 = {r[0] & ~flt[1], r[1] & ~flt[2], r[2] & ~flt[3]};
      cmp3("parallel ctls", e3, {idle_c, fms_c, slp_c});
      cmp3("parallel mode", 3'h0, {2'h0, smode});
      cmp3("slot core", {2'h0, r[9]}, {2'h0, core_run});
    end
    slot = 1'b1;
    $display("parallel test done");
    // Open pads read low, open select gives parallel
    u_rxcp_modem.set_pins(1'b1, 1'b1, 1'b1, 1'b1);
    flt = 6'h0F;
    u_rxcp_modem.tick(2);
    cmp3("open select mode", 3'h0, {2'h0, smode});
    cmp3("open pins ctls", 3'h0, {idle_c, fms_c, slp_c});
    u_rxcp_modem.set_pins(1'b0, 1'b1, 1'b0, 1'b1);
    flt = 6'h00;
    u_rxcp_modem.tick(2);
    $display("open pad test done");
    // Serial writes, back to back, then a short frame
    u_rxcp_modem.o_sel = 1'b1;
    u_rxcp_modem.o_latch = 1'b0;
    u_rxcp_modem.o_sclk = 1'b0;
    u_rxcp_modem.tick(2);
    cmp3("serial mode", 3'h1, {2'h0, smode});
    repeat (2)
    begin
      w = 16'(xs() & 32'h7FFF);
      word_q.push_back(w);
      u_rxcp_modem.frame({1'b0, w}, 16, 1'b0, -1, got);
      last_w = w;
    end
    w = 16'(xs() & 32'h7F);
    last_w = {last_w[7:0], w[7:0]};
    word_q.push_back(last_w);
    u_rxcp_modem.frame({9'h0, w[7:0]}, 8, 1'b0, -1, got);
    cmp3("ctls hold in serial", 3'h5, {idle_c, fms_c, slp_c});
    // Read-back: device drives previous word MSB first
    word_q.push_back(last_w);
    u_rxcp_modem.frame(17'h10000, 17, 1'b1, -1, got);
    cmpw("read back", last_w, got);
    cmp3("oe released", 3'h1, {2'h0, sd_oe_n});
    // Select drop in mid-frame: no word may appear
    u_rxcp_modem.frame({1'b0, 16'h1234}, 16, 1'b0, 5, got);
    cmpw("words pending", 16'h0, 16'(word_q.size()));
    $display("serial test done");
    // Slot mode stops the core and refuses conversions
    slot = 1'b0;
    u_rxcp_modem.tick(2);
    cmp3("slot core,osc", 3'h1, {1'b0, core_run, osc_run});
    u_rxcp_modem.fm_burst(1);
    cmp3("slot busy", 3'h0, {2'h0, fbusy});
    slot = 1'b1;
    u_rxcp_modem.tick(2);
    cmp3("run core,osc", 3'h3, {1'b0, core_run, osc_run});
    // Two strobe periods: restart and nine clock steps each
    fm_q.push_back(1'b1);
    fm_q.push_back(1'b1);
    u_rxcp_modem.fm_burst(2);
    cmpw("fm done busy,step", 16'h0009, {11'h0, fbusy, fstep});
    cmpw("starts pending", 16'h0, 16'(fm_q.size()));
    // Open strobe and clock pads read low: nothing starts or steps
    flt = 6'h30;
    u_rxcp_modem.fm_burst(1);
    cmpw("float fm busy,step", 16'h0009, {11'h0, fbusy, fstep});
    flt = 6'h00;
    $display("fm converter test done");
    conclude();
  end
endmodule // testbench
`default_nettype wire
